/* File: hw/pmms_core.sv */
// design: positioning mode selection and measuring system bookkeeping
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pmms_core (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] motor_enc_delta,
  input wire logic signed [15:0] material_enc_delta,
  input wire logic quick_stop,
  input wire logic power_fail,
  input wire logic power_good,
  input wire logic homing_done,
  output logic signed [31:0] speed_feedback,
  output logic signed [31:0] position_setpoint,
  output logic signed [31:0] actual_position,
  output logic home_known,
  output logic fault_pending,
  output logic moving
);
  // ************************************************************
  // helpers
  // ************************************************************
  // scale a count by num/den; truncates toward zero, fraction lost
  function automatic logic signed [31:0] pmms_scale(
    input logic signed [31:0] val,
    input logic [31:0] num,
    input logic [31:0] den
  );
    logic signed [63:0] prod;
    prod = 64'(val) * $signed({1'b0, num[30:0]});
    if (den == pmms_pkg::ZERO32)
      pmms_scale = 32'(prod);
    else
      pmms_scale = 32'(prod / $signed({33'h0, den[30:0]}));
  endfunction : pmms_scale

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [1:0] mode_req_r;
  logic [1:0] positioning_mode_select_r;
  logic actual_value_polarity_r;
  logic position_feedback_select_r;
  logic speed_feedback_select_r;
  logic [31:0] gear_num_r;
  logic [31:0] gear_den_r;
  logic signed [31:0] positive_position_limit_r;
  logic signed [31:0] negative_position_limit_r;
  logic signed [31:0] reference_offset_r;
  logic signed [31:0] home_position_setting_r;
  logic [31:0] position_resolution_r;
  logic signed [31:0] target_r;
  logic wr_cmd;

  assign wr_cmd = reg_wr && (reg_addr == pmms_pkg::ADDR_COMMAND);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_req_r <= 2'h0;
      actual_value_polarity_r <= 1'b0;
      position_feedback_select_r <= 1'b0;
      speed_feedback_select_r <= 1'b0;
      gear_num_r <= pmms_pkg::RST_GEAR;
      gear_den_r <= pmms_pkg::RST_GEAR;
      positive_position_limit_r <= pmms_pkg::RST_POS_LIMIT;
      negative_position_limit_r <= pmms_pkg::RST_NEG_LIMIT;
      reference_offset_r <= pmms_pkg::ZERO32;
      home_position_setting_r <= pmms_pkg::ZERO32;
      target_r <= pmms_pkg::ZERO32;
    end
    else if (reg_wr)
    begin
      if (reg_addr == pmms_pkg::ADDR_CTRL)
      begin
        mode_req_r <= reg_wdata[pmms_pkg::CTRL_MODE_LO +: 2];
        actual_value_polarity_r <= reg_wdata[pmms_pkg::CTRL_POLARITY];
        position_feedback_select_r <= reg_wdata[pmms_pkg::CTRL_POS_SEL];
        speed_feedback_select_r <= reg_wdata[pmms_pkg::CTRL_SPD_SEL];
      end
      else if (reg_addr == pmms_pkg::ADDR_GEAR_NUM)
        gear_num_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_GEAR_DEN)
        gear_den_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_POS_LIMIT)
        positive_position_limit_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_NEG_LIMIT)
        negative_position_limit_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_REF_OFFSET)
        reference_offset_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_HOME_SET)
        home_position_setting_r <= reg_wdata;
      else if (reg_addr == pmms_pkg::ADDR_TARGET)
        target_r <= reg_wdata;
    end
  end

  // resolution is a fixed-point inc/unit value, read-only to software
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      position_resolution_r <= pmms_pkg::RST_RESOLUTION;
    else
      position_resolution_r <= pmms_pkg::RST_RESOLUTION;
  end

  // ************************************************************
  // feedback path
  // ************************************************************
  logic signed [31:0] pos_delta;
  logic signed [31:0] pos_delta_pol;
  logic signed [31:0] spd_src;
  logic signed [31:0] machine_pos_r;

  always_comb
  begin
    // material encoder is scaled to motor increments
    if (position_feedback_select_r)
      pos_delta = pmms_scale(32'(material_enc_delta), gear_num_r,
        gear_den_r);
    else
      pos_delta = 32'(motor_enc_delta);
    // hazard: inversion dropped in quick stop gives positive feedback
    if (actual_value_polarity_r && !quick_stop)
      pos_delta_pol = -pos_delta;
    else
      pos_delta_pol = pos_delta;
    spd_src = speed_feedback_select_r ? 32'(material_enc_delta)
      : 32'(motor_enc_delta);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      speed_feedback <= pmms_pkg::ZERO32;
    else
      speed_feedback <= spd_src;
  end

  // ************************************************************
  // positioning sequence
  // ************************************************************
  typedef enum logic [1:0] {PMMS_IDLE, PMMS_CHECK, PMMS_MOVE} pmms_state_e;
  pmms_state_e state_r;
  logic signed [31:0] home_act_r;
  logic signed [31:0] saved_pos_r;
  logic signed [31:0] setpoint_r;
  logic fault_abs_r;
  logic fault_lima_r;
  logic fault_limb_r;
  logic home_known_r;
  logic cmd_abs_r;
  logic signed [31:0] contour_err;
  logic signed [31:0] tgt_real;
  logic start_req;
  logic chk_rel;
  logic chk_abs;
  logic viol_abs;
  logic viol_lima;
  logic viol_limb;
  logic viol_any;
  logic flt_any;

  assign contour_err = setpoint_r - machine_pos_r;
  // absolute-mode targets are referred to real zero (machine zero plus offset)
  assign tgt_real = target_r + reference_offset_r;
  assign start_req = wr_cmd && reg_wdata[pmms_pkg::CMD_START];
  // the check is combinational so a refused target never starts a move
  assign chk_rel = (state_r == PMMS_CHECK)
    && (positioning_mode_select_r == pmms_pkg::PMMS_MODE_REL);
  assign chk_abs = (state_r == PMMS_CHECK)
    && (positioning_mode_select_r != pmms_pkg::PMMS_MODE_REL);
  assign viol_abs = chk_rel && cmd_abs_r;
  assign viol_lima = (chk_rel && !cmd_abs_r
    && target_r > positive_position_limit_r)
    || (chk_abs && tgt_real > positive_position_limit_r);
  assign viol_limb = (chk_rel && !cmd_abs_r
    && target_r < negative_position_limit_r)
    || (chk_abs && tgt_real < negative_position_limit_r);
  assign viol_any = viol_abs || viol_lima || viol_limb;
  assign flt_any = fault_abs_r || fault_lima_r || fault_limb_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= PMMS_IDLE;
      cmd_abs_r <= 1'b0;
      positioning_mode_select_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        PMMS_IDLE:
        begin
          positioning_mode_select_r <= mode_req_r;
          if (start_req && !flt_any)
          begin
            cmd_abs_r <= reg_wdata[pmms_pkg::CMD_ABS];
            state_r <= PMMS_CHECK;
          end
        end
        PMMS_CHECK:
          state_r <= viol_any ? PMMS_IDLE : PMMS_MOVE;
        PMMS_MOVE:
          if (wr_cmd && reg_wdata[pmms_pkg::CMD_DONE])
            state_r <= PMMS_IDLE;
        default:
          state_r <= PMMS_IDLE;
      endcase
    end
  end

  // faults: set wins over acknowledge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_abs_r <= 1'b0;
      fault_lima_r <= 1'b0;
      fault_limb_r <= 1'b0;
    end
    else
    begin
      if (wr_cmd && reg_wdata[pmms_pkg::CMD_ACK])
      begin
        fault_abs_r <= 1'b0;
        fault_lima_r <= 1'b0;
        fault_limb_r <= 1'b0;
      end
      if (viol_abs)
        fault_abs_r <= 1'b1;
      if (viol_lima)
        fault_lima_r <= 1'b1;
      if (viol_limb)
        fault_limb_r <= 1'b1;
    end
  end

  // setpoint and machine position; relative moves rebase at start
  logic go;
  assign go = (state_r == PMMS_CHECK) && !viol_any;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      setpoint_r <= pmms_pkg::ZERO32;
      machine_pos_r <= pmms_pkg::ZERO32;
    end
    else if (power_good && state_r == PMMS_IDLE
      && positioning_mode_select_r == pmms_pkg::PMMS_MODE_SAVE
      && !home_known_r)
    begin
      machine_pos_r <= saved_pos_r;
      setpoint_r <= saved_pos_r;
    end
    else if (go && positioning_mode_select_r == pmms_pkg::PMMS_MODE_REL)
    begin
      setpoint_r <= target_r;
      machine_pos_r <= -contour_err + pos_delta_pol;
    end
    else
    begin
      if (go)
        setpoint_r <= tgt_real;
      machine_pos_r <= machine_pos_r + pos_delta_pol;
    end
  end

  // saved value survives resetn; only power-fail updates it
  always_ff @(posedge ref_clk)
  begin
    if (power_fail
      && positioning_mode_select_r == pmms_pkg::PMMS_MODE_SAVE)
      saved_pos_r <= machine_pos_r;
  end

  // home taken only on homing run or set-home command; also known on power-good in save mode
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      home_act_r <= pmms_pkg::ZERO32;
      home_known_r <= 1'b0;
    end
    else if (homing_done || (wr_cmd && reg_wdata[pmms_pkg::CMD_HOME]))
    begin
      home_act_r <= home_position_setting_r;
      home_known_r <= 1'b1;
    end
    else if (power_good
      && positioning_mode_select_r == pmms_pkg::PMMS_MODE_SAVE)
      home_known_r <= 1'b1;
  end

  // ************************************************************
  // outputs and read port
  // ************************************************************
  logic signed [31:0] real_act;
  assign real_act = machine_pos_r - home_act_r - reference_offset_r;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      position_setpoint <= pmms_pkg::ZERO32;
      actual_position <= pmms_pkg::ZERO32;
      home_known <= 1'b0;
      fault_pending <= 1'b0;
      moving <= 1'b0;
    end
    else
    begin
      position_setpoint <= setpoint_r - home_act_r
        - reference_offset_r;
      actual_position <= real_act;
      home_known <= home_known_r;
      fault_pending <= fault_abs_r || fault_lima_r || fault_limb_r;
      moving <= (state_r == PMMS_MOVE);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= pmms_pkg::ZERO32;
    else if (!reg_rd)
      reg_rdata <= pmms_pkg::ZERO32;
    else if (reg_addr == pmms_pkg::ADDR_CTRL)
      reg_rdata <= {27'h0, speed_feedback_select_r,
        position_feedback_select_r, actual_value_polarity_r, mode_req_r};
    else if (reg_addr == pmms_pkg::ADDR_STATUS)
      reg_rdata <= {27'h0, state_r == PMMS_MOVE, home_known_r,
        fault_limb_r, fault_lima_r, fault_abs_r};
    else if (reg_addr == pmms_pkg::ADDR_GEAR_NUM)
      reg_rdata <= gear_num_r;
    else if (reg_addr == pmms_pkg::ADDR_GEAR_DEN)
      reg_rdata <= gear_den_r;
    else if (reg_addr == pmms_pkg::ADDR_POS_LIMIT)
      reg_rdata <= positive_position_limit_r;
    else if (reg_addr == pmms_pkg::ADDR_NEG_LIMIT)
      reg_rdata <= negative_position_limit_r;
    else if (reg_addr == pmms_pkg::ADDR_REF_OFFSET)
      reg_rdata <= reference_offset_r;
    else if (reg_addr == pmms_pkg::ADDR_HOME_SET)
      reg_rdata <= home_position_setting_r;
    else if (reg_addr == pmms_pkg::ADDR_RESOLUTION)
      reg_rdata <= position_resolution_r;
    else if (reg_addr == pmms_pkg::ADDR_TARGET)
      reg_rdata <= target_r;
    else if (reg_addr == pmms_pkg::ADDR_SETPOINT)
      reg_rdata <= setpoint_r - home_act_r - reference_offset_r;
    else if (reg_addr == pmms_pkg::ADDR_ACTUAL)
      reg_rdata <= real_act;
    else if (reg_addr == pmms_pkg::ADDR_HOME_ACT)
      reg_rdata <= home_act_r;
    else if (reg_addr == pmms_pkg::ADDR_SAVED)
      reg_rdata <= saved_pos_r;
    else
      reg_rdata <= pmms_pkg::ZERO32;
  end
endmodule : pmms_core

/* File: hw/pmms_pkg.sv */
// package: constants and types of the positioning mode and measuring system
package pmms_pkg;
  // ************************************************************
  // register indices (word addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_GEAR_NUM = 8'h02;
  localparam logic [7:0] ADDR_GEAR_DEN = 8'h03;
  localparam logic [7:0] ADDR_POS_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_NEG_LIMIT = 8'h05;
  localparam logic [7:0] ADDR_REF_OFFSET = 8'h06;
  localparam logic [7:0] ADDR_HOME_SET = 8'h07;
  localparam logic [7:0] ADDR_RESOLUTION = 8'h08;
  localparam logic [7:0] ADDR_TARGET = 8'h09;
  localparam logic [7:0] ADDR_COMMAND = 8'h0a;
  localparam logic [7:0] ADDR_SETPOINT = 8'h0b;
  localparam logic [7:0] ADDR_ACTUAL = 8'h0c;
  localparam logic [7:0] ADDR_HOME_ACT = 8'h0d;
  localparam logic [7:0] ADDR_SAVED = 8'h0e;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_POLARITY = 2;
  localparam int CTRL_POS_SEL = 3;
  localparam int CTRL_SPD_SEL = 4;
  localparam int CMD_START = 0;
  localparam int CMD_ABS = 1;
  localparam int CMD_HOME = 2;
  localparam int CMD_ACK = 3;
  localparam int CMD_DONE = 4;
  localparam int ST_FAULT_ABS = 0;
  localparam int ST_FAULT_LIMA = 1;
  localparam int ST_FAULT_LIMB = 2;
  localparam int ST_HOME_KNOWN = 3;
  localparam int ST_MOVING = 4;
  // ************************************************************
  // modes, resolution and resets
  // ************************************************************
  typedef enum logic [1:0] {
    PMMS_MODE_ABS = 2'h0,
    PMMS_MODE_REL = 2'h1,
    PMMS_MODE_SAVE = 2'h2
  } pmms_mode_e;
  localparam int INC_PER_REV = 65536;
  localparam int FRAC_BITS = 16;
  localparam logic [31:0] RST_GEAR = 32'h0000_0001;
  localparam logic [31:0] RST_POS_LIMIT = 32'h7fff_ffff;
  localparam logic [31:0] RST_NEG_LIMIT = 32'h8000_0000;
  localparam logic [31:0] RST_RESOLUTION = 32'h0001_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : pmms_pkg

/* File: tb/pmms_core_monitor.sv */
// checker: port-level assertions for the positioning core
`timescale 1ns/1ps
module pmms_core_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic signed [15:0] motor_enc_delta,
  input wire logic power_good,
  input wire logic homing_done,
  input wire logic signed [31:0] speed_feedback,
  input wire logic home_known,
  input wire logic fault_pending,
  input wire logic moving
);
  // ********
  // helper state
  // ********
  logic [3:0] since_start_r;
  logic [3:0] since_ack_r;
  logic spd_sel_r;
  logic [1:0] live_r;
  wire logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == pmms_pkg::ADDR_COMMAND;

  // saturating ages, so stale commands never satisfy a check
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      since_start_r <= 4'hf;
      since_ack_r <= 4'hf;
    end
    else
    begin
      since_start_r <= (cmd_wr && reg_wdata[pmms_pkg::CMD_START]) ? 4'h0 :
        (since_start_r == 4'hf) ? 4'hf : since_start_r + 4'h1;
      since_ack_r <= (cmd_wr && reg_wdata[pmms_pkg::CMD_ACK]) ? 4'h0 :
        (since_ack_r == 4'hf) ? 4'hf : since_ack_r + 4'h1;
    end

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      spd_sel_r <= 1'b0;
      live_r <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == pmms_pkg::ADDR_CTRL)
        spd_sel_r <= reg_wdata[pmms_pkg::CTRL_SPD_SEL];
      live_r <= (live_r == 2'h3) ? 2'h3 : live_r + 2'h1;
    end

  // ********
  // assertions
  // ********
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    cmd_wr && reg_wdata[pmms_pkg::CMD_START];
  endsequence
  sequence s_held_idle;
    !moving [*4];
  endsequence

  a_resolution_read:
    assert property (reg_rd && reg_addr == pmms_pkg::ADDR_RESOLUTION |=>
      reg_rdata == pmms_pkg::RST_RESOLUTION)
    else $error("resolution read wrong");
  a_speed_motor:
    assert property (live_r == 2'h3 && !spd_sel_r && $stable(spd_sel_r) |->
      speed_feedback == 32'($past(motor_enc_delta)))
    else $error("speed feedback not from motor encoder");
  a_start_refused:
    assert property ((fault_pending && !moving) ##0 s_start |=> s_held_idle)
    else $error("move started while fault pending");
  a_fault_sticky:
    assert property ($fell(fault_pending) |-> since_ack_r <= 4'h4)
    else $error("fault cleared without ack");
  a_fault_cause:
    assert property ($rose(fault_pending) |-> since_start_r <= 4'h5)
    else $error("fault raised without start");
  a_move_cause:
    assert property ($rose(moving) |->
      since_start_r <= 4'h5 && !$past(fault_pending))
    else $error("move began without clean start");
  a_home_cause:
    assert property ($rose(home_known) |-> $past(power_good) ||
      $past(power_good, 2) || $past(power_good, 3) || $past(homing_done) ||
      $past(homing_done, 2) || $past(homing_done, 3))
    else $error("home known without cause");
  a_outs_reset:
    assert property ($rose(resetn) |-> !moving && !fault_pending && !home_known)
    else $error("outputs not cleared by reset");
  a_unmapped_read:
    assert property (reg_rd && reg_addr > pmms_pkg::ADDR_SAVED |=>
      reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : pmms_core_monitor

bind pmms_core pmms_core_monitor pmms_core_monitor_inst (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .motor_enc_delta(motor_enc_delta),
  .power_good(power_good), .homing_done(homing_done),
  .speed_feedback(speed_feedback), .home_known(home_known),
  .fault_pending(fault_pending), .moving(moving));

/* File: tb/pmms_enc_model.sv */
// model: motor and material encoders giving per-cycle increments
`timescale 1ns/1ps
module pmms_enc_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic signed [15:0] motor_step,
  input wire logic signed [15:0] material_step,
  output logic signed [15:0] motor_enc_delta,
  output logic signed [15:0] material_enc_delta
);
  // tracks wired so a clockwise turn counts up: positive step means cw
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      motor_enc_delta <= 16'h0000;
      material_enc_delta <= 16'h0000;
    end
    else
    begin
      motor_enc_delta <= run ? motor_step : 16'h0000;
      material_enc_delta <= run ? material_step : 16'h0000;
    end
endmodule : pmms_enc_model

/* File: tb/test_pmms_core.sv */
// testbench: register-level tests of the positioning core
`timescale 1ns/1ps
module test_pmms_core;
  logic ref_clk, resetn, reg_wr, reg_rd, quick_stop, power_fail;
  logic power_good, homing_done, home_known, fault_pending, moving, run;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, a_v, b_v, c_v;
  logic signed [15:0] motor_enc_delta, material_enc_delta;
  logic signed [15:0] motor_step, material_step;
  logic signed [31:0] speed_feedback, position_setpoint, actual_position;
  int error_cnt, n_checks;

  pmms_core pmms_core_inst (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .motor_enc_delta(motor_enc_delta), .material_enc_delta(material_enc_delta),
    .quick_stop(quick_stop), .power_fail(power_fail),
    .power_good(power_good), .homing_done(homing_done),
    .speed_feedback(speed_feedback), .position_setpoint(position_setpoint),
    .actual_position(actual_position), .home_known(home_known),
    .fault_pending(fault_pending), .moving(moving));
  pmms_enc_model pmms_enc_model_inst (.ref_clk(ref_clk), .resetn(resetn),
    .run(run), .motor_step(motor_step), .material_step(material_step),
    .motor_enc_delta(motor_enc_delta),
    .material_enc_delta(material_enc_delta));

  // ********
  // access and compare tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t word %h, expected %h", $time, got, exp);
    end
  end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t flag %b, expected %b", $time, got, exp);
    end
  end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
  begin
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask : rd
  // eight cycles of encoder motion; checks the position gained
  task automatic meas(input logic qs, input logic [31:0] exp);
    logic [31:0] p0;
    logic [31:0] p1;
  begin
    rd(pmms_pkg::ADDR_ACTUAL, p0);
    @(posedge ref_clk);
    quick_stop <= qs;
    run <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(speed_feedback, 32'h0000_0007);
    repeat (4) @(posedge ref_clk);
    run <= 1'b0;
    repeat (4) @(posedge ref_clk);
    quick_stop <= 1'b0;
    rd(pmms_pkg::ADDR_ACTUAL, p1);
    chk(p1 - p0, exp);
  end
  endtask : meas
  // start a positioning, check the outcome, then finish or acknowledge
  task automatic cmd(input logic [31:0] t, input logic ab, input logic [31:0] st);
    logic [31:0] v;
  begin
    wr(pmms_pkg::ADDR_TARGET, t);
    wr(pmms_pkg::ADDR_COMMAND, {30'h0, ab, 1'b1});
    repeat (5) @(posedge ref_clk);
    rd(pmms_pkg::ADDR_STATUS, v);
    chk(v & 32'h0000_0007, st);
    chk_bit(moving, st == 32'h0000_0000);
    wr(pmms_pkg::ADDR_COMMAND, (st == 0) ? 32'h0000_0010 : 32'h0000_0008);
    repeat (3) @(posedge ref_clk);
    chk_bit(moving | fault_pending, 1'b0);
  end
  endtask : cmd
  task automatic conclude();
  begin
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask : conclude

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  // ********
  // tests
  // ********
  initial
  begin
    {resetn, reg_wr, reg_rd, quick_stop, power_fail} = 5'h0;
    {power_good, homing_done, run} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    error_cnt = 0;
    n_checks = 0;
    motor_step = 16'h0007;
    material_step = 16'h0005;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    chk_bit(home_known | moving | fault_pending, 1'b0);
    rd(pmms_pkg::ADDR_CTRL, a_v);
    chk(a_v, 32'h0000_0000);
    wr(pmms_pkg::ADDR_RESOLUTION, 32'h0000_0005);
    rd(pmms_pkg::ADDR_RESOLUTION, a_v);
    chk(a_v, pmms_pkg::RST_RESOLUTION);
    rd(pmms_pkg::ADDR_POS_LIMIT, a_v);
    chk(a_v, pmms_pkg::RST_POS_LIMIT);
    rd(8'hff, a_v);
    chk(a_v, 32'h0000_0000);
    $display("test reset done");
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0008);
    meas(1'b0, 32'h0000_0028);
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_000c);
    meas(1'b0, 32'hffff_ffd8);
    // inversion dropped through this stop: the uninverted count gives positive feedback
    meas(1'b1, 32'h0000_0028);
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0008);
    wr(pmms_pkg::ADDR_GEAR_NUM, 32'h0000_0002);
    meas(1'b0, 32'h0000_0050);
    wr(pmms_pkg::ADDR_GEAR_NUM, 32'h0000_0001);
    $display("test encoder done");
    wr(pmms_pkg::ADDR_POS_LIMIT, 32'h0000_03e8);
    wr(pmms_pkg::ADDR_NEG_LIMIT, 32'hffff_fc18);
    for (int m = 0; m < 3; m += 2)
    begin
      wr(pmms_pkg::ADDR_CTRL, m);
      cmd(32'h0000_07d0, 1'b1, 32'h0000_0002);
      cmd(32'hffff_f830, 1'b1, 32'h0000_0004);
      cmd(32'h0000_01f4, 1'b1, 32'h0000_0000);
    end
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(pmms_pkg::ADDR_COMMAND, 32'h0000_0003);
    repeat (5) @(posedge ref_clk);
    chk_bit(fault_pending, 1'b1);
    wr(pmms_pkg::ADDR_COMMAND, 32'h0000_0001);
    repeat (5) @(posedge ref_clk);
    chk_bit(moving, 1'b0);
    chk_bit(fault_pending, 1'b1);
    wr(pmms_pkg::ADDR_COMMAND, 32'h0000_0008);
    repeat (3) @(posedge ref_clk);
    chk_bit(fault_pending, 1'b0);
    cmd(32'h0000_07d0, 1'b0, 32'h0000_0002);
    cmd(32'hffff_f830, 1'b0, 32'h0000_0004);
    rd(pmms_pkg::ADDR_SETPOINT, a_v);
    rd(pmms_pkg::ADDR_ACTUAL, b_v);
    cmd(32'h0000_01f4, 1'b0, 32'h0000_0000);
    rd(pmms_pkg::ADDR_SETPOINT, c_v);
    chk(c_v, 32'h0000_01f4);
    rd(pmms_pkg::ADDR_ACTUAL, c_v);
    chk(c_v, b_v - a_v);
    $display("test modes done");
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0000);
    @(posedge ref_clk);
    power_good <= 1'b1;
    repeat (3) @(posedge ref_clk);
    power_good <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(home_known, 1'b0);
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0002);
    rd(pmms_pkg::ADDR_ACTUAL, a_v);
    @(posedge ref_clk);
    power_fail <= 1'b1;
    repeat (3) @(posedge ref_clk);
    power_fail <= 1'b0;
    resetn <= 1'b0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    wr(pmms_pkg::ADDR_CTRL, 32'h0000_0002);
    @(posedge ref_clk);
    power_good <= 1'b1;
    repeat (3) @(posedge ref_clk);
    power_good <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(home_known, 1'b1);
    rd(pmms_pkg::ADDR_ACTUAL, b_v);
    chk(b_v, a_v);
    $display("test saving done");
    rd(pmms_pkg::ADDR_SETPOINT, b_v);
    wr(pmms_pkg::ADDR_REF_OFFSET, 32'h0000_0064);
    rd(pmms_pkg::ADDR_ACTUAL, c_v);
    chk(c_v, a_v - 32'h0000_0064);
    rd(pmms_pkg::ADDR_SETPOINT, c_v);
    chk(c_v, b_v - 32'h0000_0064);
    chk(position_setpoint, b_v - 32'h0000_0064);
    chk(actual_position, a_v - 32'h0000_0064);
    rd(pmms_pkg::ADDR_HOME_ACT, c_v);
    chk(c_v, 32'h0000_0000);
    wr(pmms_pkg::ADDR_HOME_SET, 32'h0000_012c);
    rd(pmms_pkg::ADDR_HOME_ACT, c_v);
    chk(c_v, 32'h0000_0000);
    @(posedge ref_clk);
    homing_done <= 1'b1;
    @(posedge ref_clk);
    homing_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(pmms_pkg::ADDR_HOME_ACT, c_v);
    chk(c_v, 32'h0000_012c);
    $display("test zero points done");
    conclude();
  end
endmodule : test_pmms_core
